// File: dv/bpcid_master.sv
`default_nettype none
module bpcid_master (
    input wire logic clk,
    input wire logic cfg_ack_ff,
    input wire logic [31:0] cfg_rdata_ff,
    output logic cfg_req,
    output logic cfg_wr,
    output logic [5:0] cfg_dword,
    output logic [3:0] cfg_be_n,
    output logic [31:0] cfg_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cfg_req = 1'b0;
        {cfg_wr, cfg_dword, cfg_be_n, cfg_wdata} = 43'h0;
    end
    // one type 0 access on the primary side, byte lanes by active-low enables
    task automatic access(input logic wr, input logic [5:0] dw, input logic [3:0] be_n,
            input logic [31:0] wd, output logic [31:0] rd, output logic ok);
        ok = 1'b0;
        rd = 32'h0;
        @(negedge clk);
        cfg_req = 1'b1;
        {cfg_wr, cfg_dword, cfg_be_n, cfg_wdata} = {wr, dw, be_n, wd};
        for (int i = 0; i < 4 && !ok; i++) begin
            @(negedge clk);
            cfg_req = 1'b0;
            // released lines must not keep showing the old value
            {cfg_wr, cfg_dword, cfg_be_n, cfg_wdata} = ~{wr, dw, be_n, wd};
            ok = cfg_ack_ff;
            rd = cfg_rdata_ff;
        end
    endtask : access
endmodule : bpcid_master
`default_nettype wire

// File: dv/bpcid_top_test.sv
`default_nettype none
module bpcid_top_test;
    import bpcid_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] MFR = 16'h1234; // arbitrary value
    localparam logic [15:0] PART = 16'h4321; // arbitrary value
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [12:0] ev = 13'h0;
    logic [31:0] p_addr = 32'h0;
    logic [31:0] rd;
    int n_mismatch = 0;
    int tests_run = 0;
    wire logic cfg_req, cfg_wr, cfg_ack_ff;
    wire logic [5:0] cfg_dword;
    wire logic [3:0] cfg_be_n;
    wire logic [31:0] cfg_wdata, cfg_rdata_ff;
    wire logic [15:0] cmd_ff;
    wire logic p_io_cyc, p_io_wr, p_io_win_hit, p_mem_cyc, p_mem_win_hit, s_cyc, s_win_hit;
    wire logic fwd_req, fbb_possible, data_perr_det, is_p_master, addr_perr_det, serr_cond;
    wire logic p_io_claim_ff, p_mem_claim_ff, p_vga_claim_ff, s_claim_ff, p_master_req_ff;
    wire logic p_fbb_go_ff, p_perr_oe_ff, dpr_set_ff, p_serr_oe_ff;
    wire logic [8:0] outs;
    assign {p_io_cyc, p_io_wr, p_io_win_hit, p_mem_cyc, p_mem_win_hit, s_cyc, s_win_hit,
        fwd_req, fbb_possible, data_perr_det, is_p_master, addr_perr_det, serr_cond} = ev;
    assign outs = {p_io_claim_ff, p_mem_claim_ff, p_vga_claim_ff, s_claim_ff, p_master_req_ff,
        p_fbb_go_ff, p_perr_oe_ff, dpr_set_ff, p_serr_oe_ff};
    always #50 clk = ~clk;
    bpcid_master m (.clk, .cfg_ack_ff, .cfg_rdata_ff, .cfg_req, .cfg_wr, .cfg_dword,
        .cfg_be_n, .cfg_wdata);
    bpcid_top #(.MFR_CODE(MFR), .PART_CODE(PART)) dut (.clk, .nrst, .cfg_req, .cfg_wr,
        .cfg_dword, .cfg_be_n, .cfg_wdata, .cfg_ack_ff, .cfg_rdata_ff, .cmd_ff, .p_io_cyc,
        .p_io_wr, .p_addr, .p_io_win_hit, .p_mem_cyc, .p_mem_win_hit, .s_cyc, .s_win_hit,
        .fwd_req, .fbb_possible, .data_perr_det, .is_p_master, .addr_perr_det, .serr_cond,
        .p_io_claim_ff, .p_mem_claim_ff, .p_vga_claim_ff, .s_claim_ff, .p_master_req_ff,
        .p_fbb_go_ff, .p_perr_oe_ff, .dpr_set_ff, .p_serr_oe_ff);
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t word got %h exp %h", $time, got, exp);
        end
    endtask : check_word
    task automatic check_outs(input logic [8:0] exp);
        tests_run++;
        if (outs !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t gated outputs got %h exp %h", $time, outs, exp);
        end
    endtask : check_outs
    task automatic cfg(input logic wr, input logic [5:0] dw, input logic [3:0] be_n,
            input logic [31:0] wd);
        logic ok;
        m.access(wr, dw, be_n, wd, rd, ok);
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED %0t no acknowledge", $time);
            end_of_test();
        end
    endtask : cfg
    // events are held one cycle, outputs follow one cycle later
    task automatic step(input logic [12:0] e, input logic [31:0] a, input logic [8:0] exp);
        @(negedge clk);
        ev = e;
        p_addr = a;
        @(negedge clk);
        ev = 13'h0;
        check_outs(exp);
    endtask : step
    task automatic scen_ident();
        cfg(1'b0, BPCID_DW_IDENT, 4'h0, 32'h0);
        check_word(rd, {PART, MFR});
        cfg(1'b0, BPCID_DW_IDENT, 4'hC, 32'h0);
        check_word(rd, {16'h0, MFR});
        cfg(1'b1, BPCID_DW_IDENT, 4'h0, 32'hFFFFFFFF);
        cfg(1'b0, BPCID_DW_IDENT, 4'h0, 32'h0);
        check_word(rd, {PART, MFR});
        cfg(1'b0, 6'h3F, 4'h0, 32'h0);
        check_word(rd, 32'h0);
    endtask : scen_ident
    task automatic scen_cmd_mask();
        cfg(1'b1, BPCID_DW_CMD, 4'h0, 32'hFFFFFFFF);
        cfg(1'b0, BPCID_DW_CMD, 4'h0, 32'h0);
        check_word(rd, 32'h00000367);
        cfg(1'b1, BPCID_DW_CMD, 4'hE, 32'h0);
        check_word({16'h0, cmd_ff}, 32'h00000300);
        cfg(1'b0, BPCID_DW_CMD, 4'hD, 32'h0);
        check_word(rd, 32'h00000300);
    endtask : scen_cmd_mask
    task automatic scen_gating();
        cfg(1'b1, BPCID_DW_CMD, 4'h0, 32'h0);
        step(13'h1FFF, 32'h3C6, 9'h000);
        cfg(1'b1, BPCID_DW_CMD, 4'h0, 32'h0367);
        step(13'h1FFF, 32'h3C6, 9'h1FF);
        cfg(1'b1, BPCID_DW_CMD, 4'h0, 32'h0040);
        step(13'h000E, 32'h0, 9'h006);
        cfg(1'b1, BPCID_DW_CMD, 4'h0, 32'h0100);
        step(13'h0002, 32'h0, 9'h000);
        step(13'h0001, 32'h0, 9'h001);
        cfg(1'b1, BPCID_DW_CMD, 4'h0, 32'h0140);
        step(13'h0002, 32'h0, 9'h001);
    endtask : scen_gating
    task automatic scen_palette();
        logic [9:0] port [3] = '{BPCID_VGA_P0, BPCID_VGA_P1, BPCID_VGA_P2};
        cfg(1'b1, BPCID_DW_CMD, 4'h0, 32'h0020);
        foreach (port[i]) step(13'h1800, {22'h00003F, port[i]}, 9'h140);
        step(13'h1800, 32'h000103C6, 9'h000);
        step(13'h1800, 32'h000003C7, 9'h000);
        step(13'h1000, 32'h000003C9, 9'h000);
        cfg(1'b1, BPCID_DW_CMD, 4'h0, 32'h0001);
        step(13'h1800, 32'h000003C8, 9'h000);
        step(13'h1C00, 32'h000003C8, 9'h100);
    endtask : scen_palette
    initial begin
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        check_word({16'h0, cmd_ff}, {16'h0, BPCID_CMD_RESET});
        check_outs(9'h000);
        scen_ident();
        scen_cmd_mask();
        scen_gating();
        scen_palette();
        end_of_test();
    end
endmodule : bpcid_top_test
`default_nettype wire

// File: src/bpcid_claim.sv
`default_nettype none
module bpcid_claim
    import bpcid_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    bpcid_cmd_if.dst cmd,
    input wire logic p_io_cyc,
    input wire logic p_io_wr,
    input wire logic [31:0] p_addr,
    input wire logic p_io_win_hit,
    input wire logic p_mem_cyc,
    input wire logic p_mem_win_hit,
    input wire logic s_cyc,
    input wire logic s_win_hit,
    input wire logic fwd_req,
    output logic p_io_claim_ff,
    output logic p_mem_claim_ff,
    output logic p_vga_claim_ff,
    output logic s_claim_ff,
    output logic p_master_req_ff
);
    // palette ports decode on ten bits; bits 15:10 are don't-care
    function automatic logic is_palette(input logic [31:0] a);
        is_palette = (a[31:16] == 16'h0000) &&
            ((a[9:0] == BPCID_VGA_P0) || (a[9:0] == BPCID_VGA_P1) || (a[9:0] == BPCID_VGA_P2));
    endfunction : is_palette

    wire logic pal_wr = p_io_cyc && p_io_wr && is_palette(p_addr);
    wire logic nxt_io = p_io_cyc && p_io_win_hit && cmd.io_en;
    wire logic nxt_mem = p_mem_cyc && p_mem_win_hit && cmd.mem_en;
    // snoop disabled: palette writes only taken through the normal io window
    wire logic nxt_vga = pal_wr && cmd.vga_snoop_en;
    wire logic nxt_s = s_cyc && s_win_hit && cmd.master_en;
    wire logic nxt_mreq = fwd_req && cmd.master_en;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            p_io_claim_ff <= 1'b0;
            p_mem_claim_ff <= 1'b0;
            p_vga_claim_ff <= 1'b0;
            s_claim_ff <= 1'b0;
            p_master_req_ff <= 1'b0;
        end else begin
            p_io_claim_ff <= nxt_io || (nxt_vga && !nxt_io);
            p_mem_claim_ff <= nxt_mem;
            p_vga_claim_ff <= nxt_vga;
            s_claim_ff <= nxt_s;
            p_master_req_ff <= nxt_mreq;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_vga_claim_decode: assert property (p_vga_claim_ff |-> $past(pal_wr))
        else $error("palette claim without palette write");
    chk_vga_snoop_gate: assert property ((pal_wr && cmd.vga_snoop_en) |=> p_io_claim_ff)
        else $error("snooped palette write not claimed");
    chk_io_gate_off: assert property ((!cmd.io_en && !(pal_wr && cmd.vga_snoop_en))
        |=> !p_io_claim_ff)
        else $error("io claimed while io space disabled");
    chk_mem_gate_off: assert property (!cmd.mem_en |=> !p_mem_claim_ff)
        else $error("memory claimed while disabled");
    chk_master_gate_off: assert property (!cmd.master_en |=>
        !s_claim_ff && !p_master_req_ff)
        else $error("upstream activity while master disabled");
endmodule : bpcid_claim
`default_nettype wire

// File: src/bpcid_cmd_if.sv
`default_nettype none
interface bpcid_cmd_if;
    logic io_en;
    logic mem_en;
    logic master_en;
    logic vga_snoop_en;
    modport src (output io_en, output mem_en, output master_en, output vga_snoop_en);
    modport dst (input io_en, input mem_en, input master_en, input vga_snoop_en);
endinterface : bpcid_cmd_if
`default_nettype wire

// File: src/bpcid_pkg.sv
`default_nettype none
package bpcid_pkg;
    localparam logic [5:0] BPCID_DW_IDENT = 6'h00;
    localparam logic [5:0] BPCID_DW_CMD = 6'h01;
    localparam logic [7:0] BPCID_OFS_MFR = 8'h00;
    localparam logic [7:0] BPCID_OFS_PART = 8'h02;
    localparam logic [7:0] BPCID_OFS_CMD = 8'h04;
    localparam logic [15:0] BPCID_CMD_RESET = 16'h0000;
    localparam logic [15:0] BPCID_CMD_WR_MASK = 16'h0367;
    localparam int BPCID_B_IO = 0;
    localparam int BPCID_B_MEM = 1;
    localparam int BPCID_B_MASTER = 2;
    localparam int BPCID_B_SPECIAL = 3;
    localparam int BPCID_B_MWI = 4;
    localparam int BPCID_B_VGA = 5;
    localparam int BPCID_B_PERR = 6;
    localparam int BPCID_B_STEP = 7;
    localparam int BPCID_B_SERR = 8;
    localparam int BPCID_B_FBB = 9;
    localparam logic [9:0] BPCID_VGA_P0 = 10'h3C6;
    localparam logic [9:0] BPCID_VGA_P1 = 10'h3C8;
    localparam logic [9:0] BPCID_VGA_P2 = 10'h3C9;
    localparam int BPCID_ACK_LAT = 1;
endpackage : bpcid_pkg
`default_nettype wire

// File: src/bpcid_top.sv
`default_nettype none
// Notes on behaviour
// - only enabled bytes written or returned
// - reserved fields and bits read zero
// - fixed maker code in low half
// - fixed part code in upper half
// - bit 0 gates primary io window claims; snooped palette writes are claimed with bit 5 alone
// - bit 1 gates primary memory claims
// - bit 2 gates upstream forwarding, not config
// - bit 3 reads zero, no special cycles
// - bit 4 reads zero, no own invalidate
// - palette write decode on ten address bits
// - bit 5 claims and forwards palette writes
// - bit 6 clear blocks parity error reporting
// - bit 6 set permits parity error reporting
// - bit 7 reads zero, no stepping
// - bit 8 enables system error drive
// - bit 9 enables fast back-to-back
module bpcid_top
    import bpcid_pkg::*;
#(
    parameter logic [15:0] MFR_CODE = 16'h5A5A, // arbitrary value
    parameter logic [15:0] PART_CODE = 16'hA5A5 // arbitrary value
)(
    input wire logic clk,
    input wire logic nrst,
    input wire logic cfg_req,
    input wire logic cfg_wr,
    input wire logic [5:0] cfg_dword,
    input wire logic [3:0] cfg_be_n,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_ack_ff,
    output logic [31:0] cfg_rdata_ff,
    output logic [15:0] cmd_ff,
    input wire logic p_io_cyc,
    input wire logic p_io_wr,
    input wire logic [31:0] p_addr,
    input wire logic p_io_win_hit,
    input wire logic p_mem_cyc,
    input wire logic p_mem_win_hit,
    input wire logic s_cyc,
    input wire logic s_win_hit,
    input wire logic fwd_req,
    input wire logic fbb_possible,
    input wire logic data_perr_det,
    input wire logic is_p_master,
    input wire logic addr_perr_det,
    input wire logic serr_cond,
    output logic p_io_claim_ff,
    output logic p_mem_claim_ff,
    output logic p_vga_claim_ff,
    output logic s_claim_ff,
    output logic p_master_req_ff,
    output logic p_fbb_go_ff,
    output logic p_perr_oe_ff,
    output logic dpr_set_ff,
    output logic p_serr_oe_ff
);
    bpcid_cmd_if cmd_bus ();

    // one dword compare, shared by every decode of the offset
    function automatic logic dw_hit(input logic [5:0] dw, input logic [5:0] want);
        dw_hit = (dw == want);
    endfunction : dw_hit

    // caller qualifies cfg_req as a primary type 0 config cycle to this device
    wire logic hit_ident = dw_hit(cfg_dword, BPCID_DW_IDENT);
    wire logic hit_cmd = dw_hit(cfg_dword, BPCID_DW_CMD);
    wire logic [31:0] be_mask;
    genvar gi;
    for (gi = 0; gi < 4; gi++) begin : g_lane
        assign be_mask[8 * gi +: 8] = {8{!cfg_be_n[gi]}};
    end
    // upper half of the command dword belongs to status, not held here
    wire logic [31:0] raw_rd = hit_ident ? {PART_CODE, MFR_CODE} :
                               hit_cmd ? {16'h0000, cmd_ff} :
                               32'h0000_0000;
    wire logic [31:0] nxt_rdata = raw_rd & be_mask;
    wire logic cmd_we = cfg_req && cfg_wr && hit_cmd;
    wire logic [15:0] wr_bits = cfg_wdata[15:0] & be_mask[15:0] & BPCID_CMD_WR_MASK;
    // read-only and reserved bits never stored, so they stay zero
    wire logic [15:0] keep_bits = cmd_ff & ~(be_mask[15:0] & BPCID_CMD_WR_MASK);
    wire logic [15:0] nxt_cmd = cmd_we ? (wr_bits | keep_bits) : cmd_ff;

    wire logic perr_en = cmd_ff[BPCID_B_PERR];
    wire logic io_en = cmd_ff[BPCID_B_IO];
    wire logic mem_en = cmd_ff[BPCID_B_MEM];
    wire logic master_en = cmd_ff[BPCID_B_MASTER];
    wire logic vga_en = cmd_ff[BPCID_B_VGA];
    wire logic serr_en = cmd_ff[BPCID_B_SERR];
    wire logic fbb_en = cmd_ff[BPCID_B_FBB];
    wire logic nxt_perr_oe = data_perr_det && perr_en;
    wire logic nxt_dpr = data_perr_det && perr_en && is_p_master;
    // address parity feeds serr only with both enables; other causes need only bit 8
    wire logic nxt_serr = cmd_ff[BPCID_B_SERR] &&
                          (serr_cond || (addr_perr_det && perr_en));
    wire logic nxt_fbb = fbb_possible && cmd_ff[BPCID_B_FBB];

    assign cmd_bus.io_en = io_en;
    assign cmd_bus.mem_en = mem_en;
    assign cmd_bus.master_en = master_en;
    assign cmd_bus.vga_snoop_en = vga_en;

    // writes always acknowledge, even when nothing lands
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cfg_ack_ff <= 1'b0;
        end else begin
            cfg_ack_ff <= cfg_req;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cmd_ff <= BPCID_CMD_RESET;
        end else begin
            cmd_ff <= nxt_cmd;
        end
    end

    // read data falls back to zero between reads so no stale word is taken
    wire logic [31:0] nxt_rd_out = (cfg_req && !cfg_wr) ? nxt_rdata : 32'h0000_0000;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cfg_rdata_ff <= 32'h0000_0000;
        end else begin
            cfg_rdata_ff <= nxt_rd_out;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            p_perr_oe_ff <= 1'b0;
        end else begin
            p_perr_oe_ff <= nxt_perr_oe;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            dpr_set_ff <= 1'b0;
        end else begin
            dpr_set_ff <= nxt_dpr;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            p_serr_oe_ff <= 1'b0;
        end else begin
            p_serr_oe_ff <= nxt_serr;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            p_fbb_go_ff <= 1'b0;
        end else begin
            p_fbb_go_ff <= nxt_fbb;
        end
    end

    // claims are gated inside; command is expected set up by software first
    bpcid_claim u_claim (
        .clk(clk),
        .nrst(nrst),
        .cmd(cmd_bus.dst),
        .p_io_cyc(p_io_cyc),
        .p_io_wr(p_io_wr),
        .p_addr(p_addr),
        .p_io_win_hit(p_io_win_hit),
        .p_mem_cyc(p_mem_cyc),
        .p_mem_win_hit(p_mem_win_hit),
        .s_cyc(s_cyc),
        .s_win_hit(s_win_hit),
        .fwd_req(fwd_req),
        .p_io_claim_ff(p_io_claim_ff),
        .p_mem_claim_ff(p_mem_claim_ff),
        .p_vga_claim_ff(p_vga_claim_ff),
        .s_claim_ff(s_claim_ff),
        .p_master_req_ff(p_master_req_ff)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_rd_ident;
        cfg_req && !cfg_wr && hit_ident && (cfg_be_n == 4'h0);
    endsequence
    sequence s_rd_cmd;
        cfg_req && !cfg_wr && hit_cmd;
    endsequence
    sequence s_wr_ident;
        cfg_req && cfg_wr && hit_ident;
    endsequence
    sequence s_wr_cmd_full;
        cfg_req && cfg_wr && hit_cmd && (cfg_be_n == 4'h0);
    endsequence
    sequence s_rd_cmd_full;
        cfg_req && !cfg_wr && hit_cmd && (cfg_be_n == 4'h0);
    endsequence
    sequence s_rd_unmapped;
        cfg_req && !cfg_wr && !hit_ident && !hit_cmd;
    endsequence
    wire logic rd_req = cfg_req && !cfg_wr;
    wire logic wr_req = cfg_req && cfg_wr;

    chk_ident_value: assert property (s_rd_ident |=>
        cfg_ack_ff && cfg_rdata_ff == {PART_CODE, MFR_CODE})
        else $error("identity dword wrong");
    chk_part_upper: assert property (s_rd_ident |=> cfg_rdata_ff[31:16] == PART_CODE)
        else $error("part code wrong");
    chk_byte_lanes: assert property (rd_req |=>
        (cfg_rdata_ff & ~$past(be_mask)) == 32'h0000_0000)
        else $error("disabled byte lane returned data");
    chk_cmd_reserved: assert property (s_rd_cmd |=>
        cfg_rdata_ff[31:10] == 22'h000000 && cfg_rdata_ff[7] == 1'b0)
        else $error("reserved command bits not zero");
    chk_ro_bits_zero: assert property (cmd_ff[BPCID_B_SPECIAL] == 1'b0 &&
        cmd_ff[BPCID_B_MWI] == 1'b0 && cmd_ff[BPCID_B_STEP] == 1'b0)
        else $error("read-only command bit became set");
    chk_ro_write_ack: assert property (s_wr_ident |=> cfg_ack_ff && $stable(cmd_ff))
        else $error("write to identity not completed cleanly");
    chk_cmd_write_lane: assert property ((cmd_we && cfg_be_n[0]) |=>
        cmd_ff[7:0] == $past(cmd_ff[7:0]))
        else $error("masked command byte changed");
    chk_cmd_write_take: assert property ((cmd_we && !cfg_be_n[0]) |=>
        cmd_ff[7:0] == ($past(cfg_wdata[7:0]) & BPCID_CMD_WR_MASK[7:0]))
        else $error("command low byte not stored");
    chk_perr_gate: assert property (!perr_en |=> !p_perr_oe_ff && !dpr_set_ff)
        else $error("parity reported while response disabled");
    chk_perr_drive: assert property ((data_perr_det && perr_en) |=> p_perr_oe_ff)
        else $error("parity error not driven");
    chk_serr_gate: assert property (!serr_en |=> !p_serr_oe_ff)
        else $error("system error driven while disabled");
    chk_fbb_gate: assert property (p_fbb_go_ff |-> $past(fbb_en))
        else $error("fast back-to-back without enable");
    chk_ack_latency: assert property (cfg_req |-> ##1 cfg_ack_ff ##1
        (!cfg_ack_ff || $past(cfg_req, 1)))
        else $error("config ack timing wrong");

    chk_ack_follow: assert property (cfg_req |=> cfg_ack_ff)
        else $error("request not acknowledged");
    chk_ack_quiet: assert property (!cfg_req |=> !cfg_ack_ff)
        else $error("acknowledge without request");
    chk_wr_rdata_zero: assert property (wr_req |=>
        cfg_rdata_ff == 32'h0000_0000)
        else $error("read data shown for a write");
    chk_idle_rdata_zero: assert property (!cfg_req |=>
        cfg_rdata_ff == 32'h0000_0000)
        else $error("read data shown while idle");
    chk_unmapped_zero: assert property (s_rd_unmapped |=>
        cfg_rdata_ff == 32'h0000_0000)
        else $error("unmapped dword returned data");
    chk_mfr_lower: assert property (s_rd_ident |=>
        cfg_rdata_ff[15:0] == MFR_CODE)
        else $error("maker code wrong");
    chk_mfr_lane0: assert property ((rd_req && hit_ident && !cfg_be_n[0]) |=>
        cfg_rdata_ff[7:0] == MFR_CODE[7:0])
        else $error("maker code low byte wrong");
    chk_part_lane3: assert property ((rd_req && hit_ident && !cfg_be_n[3]) |=>
        cfg_rdata_ff[31:24] == PART_CODE[15:8])
        else $error("part code high byte wrong");
    chk_cmd_read_value: assert property (s_rd_cmd_full |=>
        cfg_rdata_ff == {16'h0000, $past(cmd_ff)})
        else $error("command read back wrong");
    chk_status_half: assert property (s_rd_cmd |=>
        cfg_rdata_ff[31:16] == 16'h0000)
        else $error("status half not zero");
    chk_ident_after_wr: assert property (s_wr_ident ##1 s_rd_ident |=>
        cfg_rdata_ff == {PART_CODE, MFR_CODE})
        else $error("identity changed by a write");
    chk_write_readback: assert property (s_wr_cmd_full ##1 s_rd_cmd_full |=>
        cfg_rdata_ff[15:0] == ($past(cfg_wdata[15:0], 2) & BPCID_CMD_WR_MASK))
        else $error("command write not read back");

    chk_cmd_hold: assert property (!cmd_we |=> $stable(cmd_ff))
        else $error("command changed without a write");
    chk_cmd_upper_keep: assert property ((cmd_we && cfg_be_n[1]) |=>
        cmd_ff[15:8] == $past(cmd_ff[15:8]))
        else $error("masked command high byte changed");
    chk_cmd_upper_take: assert property ((cmd_we && !cfg_be_n[1]) |=>
        cmd_ff[15:8] == ($past(cfg_wdata[15:8]) & BPCID_CMD_WR_MASK[15:8]))
        else $error("command high byte not stored");
    chk_cmd_top_zero: assert property (cmd_ff[15:10] == 6'h00)
        else $error("reserved command bits stored");
    chk_special_zero: assert property (cmd_ff[BPCID_B_SPECIAL] == 1'b0)
        else $error("special cycle bit set");
    chk_mwi_zero: assert property (cmd_ff[BPCID_B_MWI] == 1'b0)
        else $error("invalidate bit set");
    chk_step_zero: assert property (cmd_ff[BPCID_B_STEP] == 1'b0)
        else $error("stepping bit set");
    chk_ro_write_clean: assert property (cmd_we |=>
        (cmd_ff & ~BPCID_CMD_WR_MASK) == 16'h0000)
        else $error("read-only command bit written");
    chk_rd_keeps_cmd: assert property (rd_req |=> $stable(cmd_ff))
        else $error("read changed the command");
    chk_no_lane_hold: assert property ((cmd_we && cfg_be_n[1:0] == 2'b11) |=> $stable(cmd_ff))
        else $error("command changed with no lane enabled");

    chk_perr_source: assert property (p_perr_oe_ff |-> $past(data_perr_det))
        else $error("parity driven without an error");
    chk_perr_quiet: assert property (!data_perr_det |=> !p_perr_oe_ff)
        else $error("parity driven while quiet");
    chk_dpr_master: assert property (!is_p_master |=> !dpr_set_ff)
        else $error("reported bit set while not master");
    chk_dpr_drive: assert property ((data_perr_det && perr_en && is_p_master) |=>
        dpr_set_ff)
        else $error("reported bit not set");
    chk_dpr_source: assert property (dpr_set_ff |-> $past(is_p_master))
        else $error("reported bit without mastership");
    chk_serr_addr_off: assert property ((addr_perr_det && !serr_cond && !perr_en) |=>
        !p_serr_oe_ff)
        else $error("address parity reported while disabled");
    chk_serr_cond_drive: assert property ((serr_cond && serr_en) |=> p_serr_oe_ff)
        else $error("system error not driven");
    chk_serr_addr_drive: assert property ((addr_perr_det && perr_en && serr_en) |=>
        p_serr_oe_ff)
        else $error("address parity not reported");
    chk_serr_enabled: assert property (p_serr_oe_ff |-> $past(serr_en))
        else $error("system error without enable");
    chk_fbb_drive: assert property ((fbb_possible && fbb_en) |=> p_fbb_go_ff)
        else $error("fast back-to-back not allowed");
    chk_fbb_off: assert property (!fbb_en |=> !p_fbb_go_ff)
        else $error("fast back-to-back while disabled");
    chk_fbb_source: assert property (p_fbb_go_ff |-> $past(fbb_possible))
        else $error("fast back-to-back without opportunity");
    chk_io_claim_source: assert property (p_io_claim_ff |-> $past(p_io_cyc))
        else $error("io claim without io cycle");
    chk_io_claim_drive: assert property ((p_io_cyc && p_io_win_hit && io_en) |=>
        p_io_claim_ff)
        else $error("io cycle not claimed");
    chk_mem_claim_drive: assert property ((p_mem_cyc && p_mem_win_hit && mem_en) |=>
        p_mem_claim_ff)
        else $error("memory cycle not claimed");
    chk_s_claim_drive: assert property ((s_cyc && s_win_hit && master_en) |=> s_claim_ff)
        else $error("secondary cycle not claimed");
    chk_mreq_drive: assert property ((fwd_req && master_en) |=> p_master_req_ff)
        else $error("upstream request dropped");
    chk_vga_claim_drive: assert property ((p_io_cyc && p_io_wr && vga_en &&
        p_addr[31:16] == 16'h0000 && p_addr[9:0] == BPCID_VGA_P1) |=> p_vga_claim_ff)
        else $error("palette write not snooped");
endmodule : bpcid_top
`default_nettype wire
